// ==== bench/host_model.sv ====
// host_model: host side of the power-on pin, plus a rails-good level.
// assumes the bench sets the pin level it wants on i_pin_req.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       i_clk,        // core clock
    input  wire logic       i_pin_req,    // wanted pin level
    input  wire logic [3:0] i_reg_en,     // regulator enables
    output logic            o_pin,        // power-on pin
    output logic            o_rails_good  // rails in regulation
);
    always @(posedge i_clk) begin
        o_pin <= i_pin_req;
    end
    // rails count as good once any regulator is on
    assign o_rails_good = |i_reg_en;
endmodule // host_model
`default_nettype wire

// ==== bench/power_up_sequencer_checker.sv ====
// power_up_sequencer_checker: port-level assertions on the sequencer.
// assumes the bench's short timing parameters, passed on by the bind.
`timescale 1ns/1ps
`default_nettype none
module power_up_sequencer_checker
    import pwrseq_pkg::*;
#(
    parameter logic [15:0] FUSE_CYC = 16'h0014,
    parameter int          SP0      = 4
) (
    input wire logic                  i_core_clk,       // clock
    input wire logic                  i_rstn,           // reset
    input wire pwrseq_pkg::apb_req_t  i_apb,            // apb request
    input wire logic [31:0]           o_prdata,         // read data
    input wire logic                  o_pready,         // ready
    input wire logic                  o_pslverr,        // error
    input wire pwrseq_pkg::fuse_cfg_t i_fuse,           // fuses
    input wire pwrseq_pkg::monitor_t  i_mon,            // monitors
    input wire logic                  i_power_on_pin,   // pin
    input wire logic [3:0]            o_reg_en,         // enables
    input wire logic                  o_power_good_pin, // power good
    input wire logic                  o_host_reset_n,   // host reset
    input wire logic                  o_fuse_load_done  // fuse done
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    // cycles since release; saturates so long runs never wrap
    logic [15:0] up_r;
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) up_r <= 16'h0000;
        else if (up_r != 16'hffff) up_r <= up_r + 16'h0001;
    end
    sequence s_slot0_on;
        $rose(o_reg_en[0]) && i_fuse.slot_code[0] == 8'h01 && i_fuse.slot_code[1] == 8'h02
            && i_fuse.slot_spacing == 2'b00;
    endsequence
    sequence s_slot1_on;
        $rose(o_reg_en[1]);
    endsequence
    reset_outs_a: assert property (disable iff (1'b0) !i_rstn |=> o_reg_en == 4'h0 && !o_host_reset_n)
        else $error("outputs active in reset");
    pready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held");
    ready_cause_a: assert property (o_pready |-> $past(i_apb.psel) && $past(i_apb.penable))
        else $error("ready without access");
    slverr_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    slot_spacing_a: assert property (s_slot0_on |-> ##SP0 s_slot1_on)
        else $error("slot spacing wrong");
    slot_order_a: assert property ($rose(o_reg_en[1]) && i_fuse.slot_code[0] == 8'h01 &&
        i_fuse.slot_code[1] == 8'h02 |-> o_reg_en[0]) else $error("order wrong");
    off_code_a: assert property (i_fuse.slot_code[3] == SLOT_OFF |-> !o_reg_en[3])
        else $error("zero code enabled");
    thermal_block_a: assert property (i_mon.thermal_shutdown && $past(i_mon.thermal_shutdown, 8)
        && o_reg_en == 4'h0 |=> o_reg_en == 4'h0) else $error("start in shutdown");
    trim_block_a: assert property (i_mon.trim_error && $past(i_mon.trim_error, 8)
        && o_reg_en == 4'h0 |=> o_reg_en == 4'h0) else $error("start with trim error");
    done_hold_a: assert property (o_fuse_load_done |=> o_fuse_load_done)
        else $error("fuse done dropped");
    done_time_a: assert property (up_r == FUSE_CYC + 16'h0004 |-> o_fuse_load_done)
        else $error("fuse done late");
endmodule // power_up_sequencer_checker
bind power_up_sequencer power_up_sequencer_checker #(.FUSE_CYC(FUSE_CYC), .SP0(int'(SP0_CYC)))
    chk_u (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_apb(i_apb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_fuse(i_fuse), .i_mon(i_mon),
    .i_power_on_pin(i_power_on_pin), .o_reg_en(o_reg_en), .o_power_good_pin(o_power_good_pin),
    .o_host_reset_n(o_host_reset_n), .o_fuse_load_done(o_fuse_load_done));
`default_nettype wire

// ==== bench/power_up_sequencer_tb.sv ====
// power_up_sequencer_tb: startup, spacing, refusal, edge mode and slave mode.
// assumes short timing parameters; the pin comes from host_model.
`timescale 1ns/1ps
`default_nettype none
module power_up_sequencer_tb;
    import pwrseq_pkg::*;
    logic        clk, rstn, pin_req, pin, rails, pready, pslverr, power_good_pin, hrst_n, done, err;
    logic [31:0] prdata, rd;
    logic [3:0]  reg_en;
    logic [5:0]  outs;
    apb_req_t    req;
    fuse_cfg_t   fuse, base, f;
    monitor_t    mon_r, mon_w;
    int          n_fail, samples_checked, t;
    logic [15:0] sp [4] = '{16'h0004, SPACING_1_CYC, SPACING_2_CYC, 16'h000a};
    logic [6:0]  bad [7] = '{7'h00, 7'h60, 7'h48, 7'h44, 7'h42, 7'h50, 7'h50};
    assign outs = {hrst_n, power_good_pin, reg_en};
    always_comb begin
        mon_w = mon_r;
        mon_w.rails_good = rails;
    end
    // spacing codes 01 and 10 keep their real lengths, so their decode is checked as built
    power_up_sequencer #(.FUSE_CYC(16'h0014), .STEST_CYC(16'h0014), .DBNC_CYC(16'h000a),
        .SP0_CYC(16'h0004), .SP3_CYC(16'h000a))
        dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_apb(req), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_fuse(fuse), .i_mon(mon_w),
        .i_power_on_pin(pin), .o_reg_en(reg_en), .o_power_good_pin(power_good_pin),
        .o_host_reset_n(hrst_n), .o_fuse_load_done(done));
    host_model host_u (.i_clk(clk), .i_pin_req(pin_req), .i_reg_en(reg_en), .o_pin(pin),
        .o_rails_good(rails));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask
    // bounded wait for one output; t reaches lim when it never came
    task automatic wait_bit(input int i, input int lim);
        t = 0;
        while (outs[i] !== 1'b1 && t < lim) begin
            @(posedge clk);
            t++;
        end
    endtask
    task automatic boot(input fuse_cfg_t c, input logic [6:0] m);
        rstn <= 1'b0;
        fuse <= c;
        mon_r <= m;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
    endtask
    task automatic conclude();
        $display("checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        conclude();
    end
    initial begin
        rstn = 1'b0;
        pin_req = 1'b1;
        req = '0;
        n_fail = 0;
        samples_checked = 0;
        base = '0;
        base.slot_code[0] = 8'h01;
        base.slot_code[1] = 8'h02;
        base.slot_code[2] = 8'h03;
        base.slot_code[4] = 8'h02;
        base.power_good_pin_gpo = 1'b1;
        base.ovlo_enable = 1'b1;
        base.ovlo_shutdown = 1'b1;
        fuse = base;
        mon_r = 7'h40;
        for (int k = 0; k < 4; k++) begin
            f = base;
            f.slot_spacing = 2'(k);
            boot(f, 7'h40);
            apb(1'b0, CTRL_OFS, 32'h0);
            chk(rd[CTRL_LPM_DIS_BIT], LPM_DIS_RST);
            wait_bit(0, 90);
            chk(t <= 80, 1'b1);
            wait_bit(1, sp[k] + 8);
            chk(t, sp[k]);
            chk({hrst_n, power_good_pin}, 2'b01);
            wait_bit(2, sp[k] + 8);
            chk(t, sp[k]);
            chk({hrst_n, reg_en[3]}, 2'b10);
        end
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h10);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd[5:4], 2'b01);
        pin_req <= 1'b0;
        apb(1'b1, CTRL_OFS, 32'h14);
        repeat (2) @(posedge clk);
        wait_bit(0, 30);
        chk(t, 30);
        pin_req <= 1'b1;
        wait_bit(0, 60);
        chk(t >= 20 && t <= 32, 1'b1);
        wait_bit(1, 40);
        chk(t, sp[3]);
        wait_bit(2, 40);
        apb(1'b1, CTRL_OFS, 32'h1);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b1, CTRL_OFS, 32'h5);
        // let the software-off clear reach the pins before timing the restart
        repeat (2) @(posedge clk);
        wait_bit(0, 30);
        chk(t < 8, 1'b1);
        for (int j = 0; j < 7; j++) begin
            f = base;
            f.ovlo_shutdown = (j != 6);
            boot(f, bad[j]);
            wait_bit(0, 120);
            chk(t == 120, j != 6);
        end
        f = base;
        f.pin_sense_select = 1'b1;
        boot(f, 7'h40);
        wait_bit(0, 100);
        chk(t, 100);
        pin_req <= 1'b0;
        wait_bit(0, 60);
        chk(t >= 10 && t <= 50, 1'b1);
        f = '0;
        f.power_good_pin_gpo = 1'b1;
        pin_req <= 1'b1;
        boot(f, 7'h40);
        repeat (90) @(posedge clk);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk({rd[STAT_SLAVE_BIT], rd[2:0]}, 4'hd);
        chk(outs, 6'h20);
        conclude();
    end
endmodule // power_up_sequencer_tb
`default_nettype wire

// ==== logic/power_up_sequencer.sv ====
// power_up_sequencer: start-up, power-up request qualification and slot sequencing.
// assumes fused values are static pins, monitor levels are asynchronous, and
// i_rstn is held low while the supply is below the undervoltage threshold.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module power_up_sequencer
    import pwrseq_pkg::*;
#(
    parameter logic [15:0] FUSE_CYC  = pwrseq_pkg::FUSE_LOAD_CYC,
    parameter logic [15:0] STEST_CYC = pwrseq_pkg::SELF_TEST_CYC,
    parameter logic [15:0] DBNC_CYC  = pwrseq_pkg::DEBOUNCE_CYC,
    parameter logic [15:0] SP0_CYC   = pwrseq_pkg::SPACING_0_CYC,
    parameter logic [15:0] SP1_CYC   = pwrseq_pkg::SPACING_1_CYC,
    parameter logic [15:0] SP2_CYC   = pwrseq_pkg::SPACING_2_CYC,
    parameter logic [15:0] SP3_CYC   = pwrseq_pkg::SPACING_3_CYC
) (
    input  wire logic                  i_core_clk,        // 40 MHz core clock
    input  wire logic                  i_rstn,            // sync reset, low below threshold
    input  wire pwrseq_pkg::apb_req_t  i_apb,             // apb request
    output logic [31:0]                o_prdata,          // apb read data
    output logic                       o_pready,          // apb ready
    output logic                       o_pslverr,         // apb error, unmapped address
    input  wire pwrseq_pkg::fuse_cfg_t i_fuse,            // fuse array outputs
    input  wire pwrseq_pkg::monitor_t  i_mon,             // asynchronous monitor levels
    input  wire logic                  i_power_on_pin,    // power-on pin, asynchronous
    output logic [3:0]                 o_reg_en,          // three bucks, one linear
    output logic                       o_power_good_pin,  // power-good / gpo pin
    output logic                       o_host_reset_n,    // host reset, low = held
    output logic                       o_fuse_load_done   // fuse mirror valid
);

    // ****************************************
    // input synchronisers
    // ****************************************
    monitor_t   mon_meta_r;
    monitor_t   mon_r;
    logic       pin_meta_r;
    logic       pin_r;
    logic       pin_d_r;

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            mon_meta_r <= '0;
            mon_r      <= '0;
            pin_meta_r <= 1'b0;
            pin_r      <= 1'b0;
            pin_d_r    <= 1'b0;
        end else begin
            mon_meta_r <= i_mon;
            mon_r      <= mon_meta_r;
            pin_meta_r <= i_power_on_pin;
            pin_r      <= pin_meta_r;
            pin_d_r    <= pin_r;
        end
    end

    // ****************************************
    // state and storage
    // ****************************************
    seq_state_t              state_r;
    seq_state_t              state_nxt;
    logic [15:0]             timer_r;
    fuse_cfg_t               mirror_r;
    logic                    fuse_done_r;
    logic                    stest_err_r;
    logic [NUM_OUT-1:0][7:0] code_r;
    logic [1:0]              spacing_r;
    logic                    lpm_dis_r;
    logic                    ovlo_en_r;
    logic                    slave_r;
    logic [7:0]              slot_r;
    logic [15:0]             tick_r;
    logic [NUM_OUT-1:0]      en_r;
    logic [15:0]             dbnc_r;
    logic                    dbnc_run_r;
    logic                    edge_req_r;

    // ****************************************
    // apb decode
    // ****************************************
    logic       acc;
    logic       wr;
    logic       in_off;
    logic       in_run;
    logic       sw_off;
    logic [7:0] max_code;
    logic [15:0] spacing_cyc;
    logic       tick_end;
    logic       last_slot;
    logic       request;
    logic       valid;

    assign acc    = i_apb.psel && i_apb.penable;
    // writes land on the edge where the slave shows ready
    assign wr     = acc && o_pready && i_apb.pwrite;
    assign in_off = (state_r == ST_OFF);
    assign in_run = (state_r == ST_RUN);
    assign sw_off = wr && in_run && (i_apb.paddr == CTRL_OFS)
                    && i_apb.pwdata[CTRL_SW_OFF_BIT];

    // ****************************************
    // request qualification
    // ****************************************
    // edge mode: a falling edge arms the debounce, any high level aborts it
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            dbnc_run_r <= 1'b0;
            dbnc_r     <= '0;
            edge_req_r <= 1'b0;
        end else begin
            if (pin_r) begin
                dbnc_run_r <= 1'b0;
                dbnc_r     <= '0;
            end else if (pin_d_r) begin
                dbnc_run_r <= 1'b1;
                dbnc_r     <= '0;
            end else if (dbnc_run_r) begin
                dbnc_r <= dbnc_r + 16'h0001;
            end
            if (dbnc_run_r && !pin_r && (dbnc_r == DBNC_CYC - 16'h0001)) begin
                edge_req_r <= 1'b1;
                dbnc_run_r <= 1'b0;
            end else if (state_r == ST_SEQ || in_run) begin
                edge_req_r <= 1'b0;
            end
        end
    end

    assign request = mirror_r.pin_sense_select ? edge_req_r : pin_r;
    assign valid   = in_off && request
                     && mon_r.supply_ok
                     && !mon_r.thermal_shutdown
                     && !(mon_r.overvoltage && ovlo_en_r
                          && mirror_r.ovlo_shutdown)
                     && !mon_r.trim_error
                     && !mon_r.fuse_error
                     && !stest_err_r;

    // ****************************************
    // sequencer timing
    // ****************************************
    always_comb begin
        unique case (spacing_r)
            2'b00: spacing_cyc = SP0_CYC;
            2'b01: spacing_cyc = SP1_CYC;
            2'b10: spacing_cyc = SP2_CYC;
            2'b11: spacing_cyc = SP3_CYC;
        endcase
    end

    always_comb begin
        max_code = SLOT_OFF;
        for (int i = 0; i < NUM_OUT; i++) begin
            if (code_r[i] > max_code) begin
                max_code = code_r[i];
            end
        end
    end

    assign tick_end  = (tick_r == spacing_cyc - 16'h0001);
    // the highest slot is enabled in the same cycle that run is entered
    assign last_slot = ({1'b0, slot_r} + 9'h001) >= {1'b0, max_code};

    // ****************************************
    // main state machine
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_FUSE: begin
                if (timer_r == FUSE_CYC - 16'h0001) begin
                    state_nxt = ST_STEST;
                end
            end
            ST_STEST: begin
                if (timer_r == STEST_CYC - 16'h0001) begin
                    state_nxt = ST_OFF;
                end
            end
            ST_OFF: begin
                if (valid) begin
                    // deep off must bring circuits back and retest
                    state_nxt = lpm_dis_r ? ST_SEQ : ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (timer_r == STEST_CYC - 16'h0001) begin
                    // a failed retest drops back to off, where the error flag blocks requests
                    state_nxt = mon_r.self_test_fail ? ST_OFF : ST_SEQ;
                end
            end
            ST_SEQ: begin
                if (last_slot) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sw_off) begin
                    state_nxt = ST_OFF;
                end
            end
            default: state_nxt = ST_FUSE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            state_r <= ST_FUSE;
            timer_r <= '0;
        end else begin
            state_r <= state_nxt;
            timer_r <= (state_nxt != state_r) ? 16'h0000 : timer_r + 16'h0001;
        end
    end

    // ****************************************
    // fuse mirror and self-test result
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            mirror_r    <= '0;
            fuse_done_r <= 1'b0;
            stest_err_r <= 1'b0;
        end else begin
            if (state_r == ST_FUSE && state_nxt == ST_STEST) begin
                mirror_r    <= i_fuse;
                fuse_done_r <= 1'b1;
            end
            if ((state_r == ST_STEST || state_r == ST_WAKE) && state_nxt != state_r) begin
                stest_err_r <= mon_r.self_test_fail;
            end
        end
    end

    // ****************************************
    // software-visible configuration
    // ****************************************
    // slot codes and spacing fall back to the mirror on a software off; the ovlo enable keeps its written value
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            code_r    <= '0;
            spacing_r <= '0;
            ovlo_en_r <= 1'b0;
        end else if (state_r == ST_FUSE && state_nxt == ST_STEST) begin
            code_r    <= i_fuse.slot_code;
            spacing_r <= i_fuse.slot_spacing;
            ovlo_en_r <= i_fuse.ovlo_enable;
        end else if (sw_off) begin
            code_r    <= mirror_r.slot_code;
            spacing_r <= mirror_r.slot_spacing;
        end else if (wr && in_run) begin
            if (i_apb.paddr == CTRL_OFS) begin
                spacing_r <= i_apb.pwdata[CTRL_SPACING_LSB +: 2];
                ovlo_en_r <= i_apb.pwdata[CTRL_OVLO_EN_BIT];
            end
            if (i_apb.paddr == SLOTS0_OFS) begin
                code_r[3:0] <= i_apb.pwdata;
            end
            if (i_apb.paddr == SLOTS1_OFS) begin
                code_r[RESET_IDX:POWER_GOOD_PIN_IDX] <= i_apb.pwdata[15:0];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            lpm_dis_r <= LPM_DIS_RST;
        end else if (wr && in_run && i_apb.paddr == CTRL_OFS) begin
            lpm_dis_r <= i_apb.pwdata[CTRL_LPM_DIS_BIT];
        end
    end

    // ****************************************
    // slot sequencer
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            slot_r  <= '0;
            tick_r  <= '0;
            en_r    <= '0;
            slave_r <= 1'b0;
        end else if (sw_off) begin
            en_r    <= '0;
            slave_r <= 1'b0;
        end else if (state_r == ST_SEQ) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                // a zero code never matches since slot+1 is at least one
                if ({1'b0, code_r[i]} == {1'b0, slot_r} + 9'h001) begin
                    en_r[i] <= 1'b1;
                end
            end
            if (last_slot) begin
                slave_r         <= (max_code == SLOT_OFF);
                en_r[RESET_IDX] <= 1'b1;
            end
            if (tick_end) begin
                tick_r <= '0;
                slot_r <= slot_r + 8'h01;
            end else begin
                tick_r <= tick_r + 16'h0001;
            end
        end else begin
            slot_r <= '0;
            tick_r <= '0;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_reg_en         <= '0;
            o_power_good_pin <= 1'b0;
            o_host_reset_n   <= 1'b0;
            o_fuse_load_done <= 1'b0;
        end else begin
            o_reg_en         <= en_r[3:0];
            o_power_good_pin <= mirror_r.power_good_pin_gpo ? en_r[POWER_GOOD_PIN_IDX]
                                : (in_run && mon_r.rails_good);
            o_host_reset_n   <= en_r[RESET_IDX];
            o_fuse_load_done <= fuse_done_r;
        end
    end

    // ****************************************
    // apb slave: one wait state, data registered with ready
    // ****************************************
    logic        mapped;
    logic [31:0] rd_word;

    assign mapped = (i_apb.paddr == CTRL_OFS) || (i_apb.paddr == STATUS_OFS)
                    || (i_apb.paddr == SLOTS0_OFS) || (i_apb.paddr == SLOTS1_OFS);

    always_comb begin
        rd_word = '0;
        unique case (i_apb.paddr)
            CTRL_OFS: begin
                rd_word[CTRL_LPM_DIS_BIT]       = lpm_dis_r;
                rd_word[CTRL_OVLO_EN_BIT]       = ovlo_en_r;
                rd_word[CTRL_SPACING_LSB +: 2]  = spacing_r;
            end
            STATUS_OFS: begin
                rd_word[STAT_STATE_LSB +: 3]    = state_r;
                rd_word[STAT_FUSE_DONE]         = fuse_done_r;
                rd_word[STAT_SLAVE_BIT]         = slave_r;
                rd_word[STAT_STEST_ERR]         = stest_err_r;
                rd_word[STAT_FUSE_ERR]          = mon_r.fuse_error;
                rd_word[STAT_TRIM_ERR]          = mon_r.trim_error;
                rd_word[STAT_SLOT_LSB +: 8]     = slot_r;
            end
            SLOTS0_OFS: rd_word = code_r[3:0];
            SLOTS1_OFS: rd_word[15:0] = code_r[RESET_IDX:POWER_GOOD_PIN_IDX];
            default:    rd_word = '0;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_pready  <= 1'b0;
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
        end else if (acc && !o_pready) begin
            o_pready  <= 1'b1;
            o_prdata  <= i_apb.pwrite ? 32'h0000_0000 : rd_word;
            o_pslverr <= !mapped;
        end else begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

endmodule // power_up_sequencer

`default_nettype wire

// ==== logic/pwrseq_pkg.sv ====
// pwrseq_pkg: shared constants, register map and types of the power-up sequencer.
// assumes a single 40 MHz core clock and a synchronous reset released at supply rise.
package pwrseq_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_MHZ           = 40;      // core clock rate, MHz
    localparam int FUSE_LOAD_US      = 600;     // longest fuse load time
    localparam int SELF_TEST_US      = 400;     // self-test window, startup and wake
    localparam int DEBOUNCE_US       = 1000;    // pin debounce in edge mode
    localparam int SPACING_0_US      = 30;
    localparam int SPACING_1_US      = 120;
    localparam int SPACING_2_US      = 250;
    localparam int SPACING_3_US      = 500;
    localparam int FIRST_SLOT_MAX_US = 1500;    // supply rise to first slot
    localparam int WAKE_MAX_US       = 800;     // pin high to first slot from deep off
    localparam int BUDGET_US         = 5000;    // whole power-up, level mode only

    localparam logic [15:0] FUSE_LOAD_CYC = 16'(FUSE_LOAD_US * CLK_MHZ);
    localparam logic [15:0] SELF_TEST_CYC = 16'(SELF_TEST_US * CLK_MHZ);
    localparam logic [15:0] DEBOUNCE_CYC  = 16'(DEBOUNCE_US * CLK_MHZ);
    localparam logic [15:0] SPACING_0_CYC = 16'(SPACING_0_US * CLK_MHZ);
    localparam logic [15:0] SPACING_1_CYC = 16'(SPACING_1_US * CLK_MHZ);
    localparam logic [15:0] SPACING_2_CYC = 16'(SPACING_2_US * CLK_MHZ);
    localparam logic [15:0] SPACING_3_CYC = 16'(SPACING_3_US * CLK_MHZ);

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] SLOTS0_OFS = 12'h008;
    localparam logic [11:0] SLOTS1_OFS = 12'h00c;

    // control fields
    localparam int CTRL_LPM_DIS_BIT = 0;
    localparam int CTRL_OVLO_EN_BIT = 1;
    localparam int CTRL_SW_OFF_BIT  = 2;
    localparam int CTRL_SPACING_LSB = 4;
    // status fields
    localparam int STAT_STATE_LSB   = 0;
    localparam int STAT_FUSE_DONE   = 4;
    localparam int STAT_SLAVE_BIT   = 5;
    localparam int STAT_STEST_ERR   = 6;
    localparam int STAT_FUSE_ERR    = 7;
    localparam int STAT_TRIM_ERR    = 8;
    localparam int STAT_SLOT_LSB    = 16;

    localparam int NUM_OUT   = 6;  // 4 regulators, power-good gpo, host reset
    localparam int POWER_GOOD_PIN_IDX = 4;
    localparam int RESET_IDX = 5;

    localparam logic       LPM_DIS_RST = 1'b0;
    localparam logic [7:0] SLOT_OFF    = 8'h00;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_FUSE  = 3'b000,
        ST_STEST = 3'b001,
        ST_OFF   = 3'b010,
        ST_WAKE  = 3'b011,
        ST_SEQ   = 3'b100,
        ST_RUN   = 3'b101
    } seq_state_t;

    typedef struct packed {
        logic [NUM_OUT-1:0][7:0] slot_code;
        logic [1:0]              slot_spacing;
        logic                    pin_sense_select;
        logic                    ovlo_shutdown;
        logic                    ovlo_enable;
        logic                    power_good_pin_gpo;
    } fuse_cfg_t;

    typedef struct packed {
        logic        supply_ok;
        logic        thermal_shutdown;
        logic        overvoltage;
        logic        trim_error;
        logic        fuse_error;
        logic        self_test_fail;
        logic        rails_good;
    } monitor_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage
